// >>> logic/smcs_mem_if.sv
// connection between the command slave and its byte store
`timescale 1ns/1ns
interface smcs_mem_if;
  logic                      we;
  logic [smcs_pkg::ADDR_W-1:0] waddr;
  logic [smcs_pkg::DATA_W-1:0] wdata;
  logic [smcs_pkg::ADDR_W-1:0] raddr;
  logic [smcs_pkg::DATA_W-1:0] rdata;
  logic                      nv_we;
  logic [2:0]                nv_wdata;
  logic [2:0]                nv_q;
  modport ctrl  (output we, waddr, wdata, raddr, nv_we, nv_wdata, input rdata, nv_q);
  modport store (input we, waddr, wdata, raddr, nv_we, nv_wdata, output rdata, nv_q);
endinterface

// >>> logic/smcs_pkg.sv
// constants and types for the serial memory command slave
package smcs_pkg;
  localparam int          ADDR_W             = 11;
  localparam int          DATA_W             = 8;
  localparam logic [7:0]  CMD_LATCH_SET      = 8'h06;
  localparam logic [7:0]  CMD_LATCH_CLEAR    = 8'h04;
  localparam logic [7:0]  CMD_STATUS_READ    = 8'h05;
  localparam logic [7:0]  CMD_STATUS_WRITE   = 8'h01;
  localparam logic [7:0]  CMD_MEM_READ       = 8'h03;
  localparam logic [7:0]  CMD_MEM_WRITE      = 8'h02;
  localparam int          STAT_PIN_LOCK      = 7;
  localparam int          STAT_BP_HI         = 3;
  localparam int          STAT_BP_LO         = 2;
  localparam int          STAT_LATCH         = 1;
  localparam int          NV_PIN_LOCK        = 2;
  localparam int          NV_BP_HI           = 1;
  localparam int          NV_BP_LO           = 0;
  localparam logic [2:0]  NV_INIT            = 3'h0;
  localparam logic [1:0]  BP_NONE            = 2'h0;
  localparam logic [1:0]  BP_QUARTER         = 2'h1;
  localparam logic [1:0]  BP_HALF            = 2'h2;
  localparam logic [10:0] PROT_QUARTER_BASE  = 11'h600;
  localparam logic [10:0] PROT_HALF_BASE     = 11'h400;
  localparam logic [10:0] ADDR_LAST          = 11'h7ff;
  localparam logic [10:0] ADDR_FIRST         = 11'h000;
  localparam logic [10:0] ADDR_STEP          = 11'h001;
  localparam logic [2:0]  BIT_FIRST          = 3'h0;
  localparam logic [2:0]  BIT_LAST           = 3'h7;
  localparam logic [2:0]  BIT_STEP           = 3'h1;
  localparam int          HI_ADDR_BITS       = 3;
  localparam int          SYNC_W             = 5;
  localparam int          IN_CS              = 0;
  localparam int          IN_SCK             = 1;
  localparam int          IN_SI              = 2;
  localparam int          IN_HOLD            = 3;
  localparam int          IN_WP              = 4;
  // pins idle: select, pause and protect high, clock and data low
  localparam logic [4:0]  SYNC_IDLE          = 5'h19;

  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_CMD   = 8'h02,
    ST_ADDR  = 8'h04,
    ST_RDATA = 8'h08,
    ST_WDATA = 8'h10,
    ST_SRD   = 8'h20,
    ST_SWR   = 8'h40,
    ST_DONE  = 8'h80
  } smcs_state_e;

  typedef struct packed {
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic              sck_prev;
    logic              cs_prev;
    smcs_state_e       state;
    logic [2:0]        cnt;
    logic [7:0]        shift_in;
    logic [7:0]        out_sh;
    logic [ADDR_W-1:0] addr;
    logic              addr_hi;
    logic              cmd_wr;
    logic              write_latch_flag;
    logic              wrote;
    logic              drv;
    logic              so;
    logic              so_oe;
  } smcs_regs_s;

  localparam smcs_regs_s REGS_RESET = '{
    sync1:    SYNC_IDLE,
    sync2:    SYNC_IDLE,
    sck_prev: 1'b0,
    cs_prev:  1'b1,
    state:    ST_IDLE,
    cnt:      BIT_FIRST,
    shift_in: 8'h00,
    out_sh:   8'h00,
    addr:     ADDR_FIRST,
    addr_hi:  1'b0,
    cmd_wr:   1'b0,
    write_latch_flag:      1'b0,
    wrote:    1'b0,
    drv:      1'b0,
    so:       1'b0,
    so_oe:    1'b0
  };
endpackage

// >>> logic/smcs_slave.sv
// serial memory command slave: link decode, latch, protection, transfers
`timescale 1ns/1ns
module smcs_slave (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic cs_n_in,
  input  wire logic sck_in,
  input  wire logic si_in,
  input  wire logic hold_n_in,
  input  wire logic wp_n_in,
  output logic      so_out,
  output logic      so_oe_out
);
  smcs_pkg::smcs_regs_s r;
  smcs_pkg::smcs_regs_s next_r;
  smcs_mem_if           mem ();

  logic       cs_s;
  logic       sck_s;
  logic       si_s;
  logic       hold_s;
  logic       wp_s;
  logic       cs_fall;
  logic       rise_e;
  logic       fall_e;
  logic       active;
  logic [7:0] in_byte;
  logic [7:0] status_byte;
  logic [7:0] out_byte;
  logic [1:0] bp;
  logic       lock;
  logic       sw_ok;
  logic       byte_end;
  logic       wbyte_done;
  logic       swr_done;
  logic       cmd_done;

  // range check is used by the write path only; its check restates the ranges
  // block protect ranges
  function automatic logic is_prot(input logic [smcs_pkg::ADDR_W-1:0] a,
                                   input logic [1:0] b);
    logic p;
    p = 1'b1;
    if (b == smcs_pkg::BP_NONE) begin
      p = 1'b0;
    end else if (b == smcs_pkg::BP_QUARTER) begin
      p = (a >= smcs_pkg::PROT_QUARTER_BASE);
    end else if (b == smcs_pkg::BP_HALF) begin
      p = (a >= smcs_pkg::PROT_HALF_BASE);
    end
    return p;
  endfunction

  smcs_store u_store (
    .clk_in (clk_in),
    .mem    (mem)
  );

  // only second stage flops are read; first stage feeds nothing else
  assign cs_s    = r.sync2[smcs_pkg::IN_CS];
  assign sck_s   = r.sync2[smcs_pkg::IN_SCK];
  assign si_s    = r.sync2[smcs_pkg::IN_SI];
  assign hold_s  = r.sync2[smcs_pkg::IN_HOLD];
  assign wp_s    = r.sync2[smcs_pkg::IN_WP];
  assign cs_fall = r.cs_prev && !cs_s;
  assign active  = !cs_s && hold_s && !cs_fall;
  assign rise_e  = active && sck_s && !r.sck_prev;
  assign fall_e  = active && !sck_s && r.sck_prev;
  assign in_byte = {r.shift_in[6:0], si_s};

  assign bp   = {mem.nv_q[smcs_pkg::NV_BP_HI], mem.nv_q[smcs_pkg::NV_BP_LO]};
  assign lock = mem.nv_q[smcs_pkg::NV_PIN_LOCK];
  assign sw_ok = r.write_latch_flag && !(lock && !wp_s);

  always_comb begin
    status_byte = 8'h00;
    status_byte[smcs_pkg::STAT_PIN_LOCK] = lock;
    status_byte[smcs_pkg::STAT_BP_HI]    = bp[1];
    status_byte[smcs_pkg::STAT_BP_LO]    = bp[0];
    status_byte[smcs_pkg::STAT_LATCH]    = r.write_latch_flag;
  end

  assign byte_end   = rise_e && (r.cnt == smcs_pkg::BIT_LAST);
  assign cmd_done   = byte_end && (r.state == smcs_pkg::ST_CMD);
  assign wbyte_done = byte_end && (r.state == smcs_pkg::ST_WDATA);
  assign swr_done   = byte_end && (r.state == smcs_pkg::ST_SWR);

  assign mem.we    = wbyte_done && r.write_latch_flag && !is_prot(r.addr, bp);
  assign mem.waddr = r.addr;
  assign mem.wdata = in_byte;
  assign mem.raddr = r.addr;
  assign mem.nv_we    = swr_done && sw_ok;
  assign mem.nv_wdata = {in_byte[smcs_pkg::STAT_PIN_LOCK], in_byte[smcs_pkg::STAT_BP_HI],
                         in_byte[smcs_pkg::STAT_BP_LO]};

  always_comb begin
    next_r = r;
    out_byte = (r.state == smcs_pkg::ST_RDATA) ? mem.rdata : status_byte;
    next_r.sync1    = {wp_n_in, hold_n_in, si_in, sck_in, cs_n_in};
    next_r.sync2    = r.sync1;
    next_r.sck_prev = sck_s;
    next_r.cs_prev  = cs_s;
    if (cs_s) begin
      next_r.state   = smcs_pkg::ST_IDLE;
      next_r.cnt     = smcs_pkg::BIT_FIRST;
      next_r.addr_hi = 1'b0;
      next_r.drv     = 1'b0;
      next_r.wrote   = 1'b0;
      if (r.wrote) begin
        next_r.write_latch_flag = 1'b0;
      end
    end else if (cs_fall) begin
      // idle level captured
      // a clock already high at select is mode 3; its first fall is no edge of ours
      next_r.state = smcs_pkg::ST_CMD;
      next_r.cnt   = smcs_pkg::BIT_FIRST;
    end else if (rise_e && (r.state == smcs_pkg::ST_CMD || r.state == smcs_pkg::ST_ADDR ||
                            r.state == smcs_pkg::ST_WDATA || r.state == smcs_pkg::ST_SWR)) begin
      next_r.shift_in = in_byte;
      next_r.cnt      = r.cnt + smcs_pkg::BIT_STEP;
      if (r.cnt == smcs_pkg::BIT_LAST) begin
        case (r.state)
          smcs_pkg::ST_CMD: begin
            if (in_byte == smcs_pkg::CMD_LATCH_SET) begin
              next_r.write_latch_flag   = 1'b1;
              next_r.state = smcs_pkg::ST_DONE;
            end else if (in_byte == smcs_pkg::CMD_LATCH_CLEAR) begin
              next_r.write_latch_flag   = 1'b0;
              next_r.state = smcs_pkg::ST_DONE;
            end else if (in_byte == smcs_pkg::CMD_STATUS_WRITE) begin
              next_r.state = smcs_pkg::ST_SWR;
            end else if (in_byte == smcs_pkg::CMD_STATUS_READ) begin
              next_r.state = smcs_pkg::ST_SRD;
            end else if (in_byte == smcs_pkg::CMD_MEM_READ ||
                         in_byte == smcs_pkg::CMD_MEM_WRITE) begin
              next_r.state  = smcs_pkg::ST_ADDR;
              next_r.cmd_wr = (in_byte == smcs_pkg::CMD_MEM_WRITE);
            end else begin
              // unknown codes idle until deselect
              next_r.state = smcs_pkg::ST_DONE;
            end
          end
          smcs_pkg::ST_ADDR: begin
            if (!r.addr_hi) begin
              next_r.addr_hi = 1'b1;
              next_r.addr[smcs_pkg::ADDR_W-1:8] = in_byte[smcs_pkg::HI_ADDR_BITS-1:0];
            end else begin
              next_r.addr[7:0] = in_byte;
              next_r.state = r.cmd_wr ? smcs_pkg::ST_WDATA : smcs_pkg::ST_RDATA;
            end
          end
          smcs_pkg::ST_WDATA: begin
            next_r.addr = r.addr + smcs_pkg::ADDR_STEP;
            if (r.write_latch_flag) begin
              next_r.wrote = 1'b1;
            end
          end
          smcs_pkg::ST_SWR: begin
            if (sw_ok) begin
              next_r.write_latch_flag = 1'b0;
            end
            next_r.state = smcs_pkg::ST_DONE;
          end
          default: begin
          end
        endcase
      end
    end else if (fall_e && (r.state == smcs_pkg::ST_RDATA ||
                            r.state == smcs_pkg::ST_SRD)) begin
      next_r.drv = 1'b1;
      next_r.cnt = r.cnt + smcs_pkg::BIT_STEP;
      if (r.cnt == smcs_pkg::BIT_FIRST) begin
        next_r.so     = out_byte[7];
        next_r.out_sh = {out_byte[6:0], 1'b0};
        if (r.state == smcs_pkg::ST_RDATA) begin
          next_r.addr = r.addr + smcs_pkg::ADDR_STEP;
        end
      end else begin
        next_r.so     = r.out_sh[7];
        next_r.out_sh = {r.out_sh[6:0], 1'b0};
      end
    end
    next_r.so_oe = next_r.drv && hold_s && !cs_s;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      r <= smcs_pkg::REGS_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign so_out    = r.so;
  assign so_oe_out = r.so_oe;

  // checks on the slave's own behaviour
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  sequence latch_cmd_s(logic [7:0] code);
    cmd_done && (in_byte == code);
  endsequence

  sequence swr_locked_s;
    swr_done && lock && !wp_s;
  endsequence

  latch_set_a: assert property (latch_cmd_s(smcs_pkg::CMD_LATCH_SET) |=> r.write_latch_flag)
    else $error("latch set command did not set latch");
  latch_clear_a: assert property (latch_cmd_s(smcs_pkg::CMD_LATCH_CLEAR) |=> !r.write_latch_flag)
    else $error("latch clear command left latch set");
  status_lock_a: assert property (swr_locked_s |-> ##2 mem.nv_q == $past(mem.nv_q, 2))
    else $error("locked status write changed protection bits");
  status_wel_a: assert property (swr_done && sw_ok |=> !r.write_latch_flag ##1 !r.write_latch_flag)
    else $error("status write did not clear latch");
  prot_write_a: assert property (mem.we |-> r.write_latch_flag && (bp != ~smcs_pkg::BP_NONE) &&
      !(bp == smcs_pkg::BP_HALF && mem.waddr >= smcs_pkg::PROT_HALF_BASE) &&
      !(bp == smcs_pkg::BP_QUARTER && mem.waddr >= smcs_pkg::PROT_QUARTER_BASE))
    else $error("array write while latch clear or range protected");
  addr_wrap_a: assert property (wbyte_done && r.addr == smcs_pkg::ADDR_LAST
                                |=> r.addr == smcs_pkg::ADDR_FIRST)
    else $error("address did not wrap to zero");
  deselect_oe_a: assert property (cs_s |=> !so_oe_out)
    else $error("output driven while deselected");
  pause_oe_a: assert property (!hold_s |=> !so_oe_out)
    else $error("output driven while paused");
  oe_phase_a: assert property (so_oe_out |-> r.state inside {smcs_pkg::ST_RDATA,
                                                             smcs_pkg::ST_SRD})
    else $error("output driven outside a read phase");
  so_fall_a: assert property ($changed(so_out) |-> $past(fall_e))
    else $error("serial output changed without a falling clock");
  pause_hold_a: assert property (!hold_s && !cs_s && !cs_fall |=> $stable(r.cnt))
    else $error("bit position moved while paused");
  one_cmd_a: assert property (r.state == smcs_pkg::ST_DONE && !cs_s
                              |=> r.state == smcs_pkg::ST_DONE)
    else $error("second command accepted in one select");
  write_end_a: assert property (cs_s && r.wrote |=> !r.write_latch_flag)
    else $error("array write end did not clear latch");
  swr_refuse_a: assert property (swr_done && !sw_ok |=> r.write_latch_flag == $past(r.write_latch_flag))
    else $error("refused status write changed latch");
  read_step_a: assert property (fall_e && r.state == smcs_pkg::ST_RDATA &&
                                r.cnt == smcs_pkg::BIT_FIRST
                                |=> r.addr == $past(r.addr) + smcs_pkg::ADDR_STEP)
    else $error("read address did not advance by one");
  read_ignore_a: assert property (rise_e && r.state == smcs_pkg::ST_RDATA |=> $stable(r.shift_in))
    else $error("input shifted during read data phase");
endmodule

// >>> logic/smcs_store.sv
// byte array and retained protection bits
`timescale 1ns/1ns
module smcs_store #(
  parameter int ADDR_W = smcs_pkg::ADDR_W
) (
  input  wire logic     clk_in,
  smcs_mem_if.store     mem
);
  logic [smcs_pkg::DATA_W-1:0] array [0:(1<<ADDR_W)-1];
  // retained bits take no reset so they survive a reset pulse
  logic [2:0]                  nv = smcs_pkg::NV_INIT;

  always_ff @(posedge clk_in) begin
    if (mem.we) begin
      array[mem.waddr] <= mem.wdata;
    end
    mem.rdata <= array[mem.raddr];
    if (mem.nv_we) begin
      nv <= mem.nv_wdata;
    end
  end

  assign mem.nv_q = nv;
endmodule

// >>> tb/smcs_host.sv
// host-side serial master model driving the slave's link pins
`timescale 1ns/1ns
module smcs_host (
  input  wire logic clk_in,
  output logic      cs_n_out   = 1'b1,
  output logic      sck_out    = 1'b0,
  output logic      si_out     = 1'b0,
  output logic      hold_n_out = 1'b1,
  output logic      wp_n_out   = 1'b1
);
  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  task automatic set_wp(input logic v);
    @(negedge clk_in);
    wp_n_out = v;
  endtask

  // low phase of 5 clk lets slave output settle before our sampling rise
  task automatic send_bit(input logic b, input bit pause);
    sck_out = 1'b0;
    si_out  = b;
    tick(5);
    if (pause) begin
      hold_n_out = 1'b0;
      repeat (2) begin
        tick(3);
        sck_out = 1'b1;
        tick(3);
        sck_out = 1'b0;
      end
      tick(3);
      hold_n_out = 1'b1;
      tick(5);
    end
    sck_out = 1'b1;
    tick(3);
  endtask

  task automatic frame(input logic [7:0] tx [8], input int ntx, input int nrx,
                       input bit cpol, input int pause_at);
    int         i;
    int         k;
    logic [7:0] b;
    @(negedge clk_in);
    sck_out = cpol;
    tick(2);
    cs_n_out = 1'b0;
    tick(4);
    for (i = 0; i < ntx + nrx; i++) begin
      // input is ignored in read phases, so send noise there
      b = (i < ntx) ? tx[i] : 8'($urandom);
      for (k = 7; k >= 0; k--) begin
        send_bit(b[k], i == pause_at && k == 3);
      end
    end
    sck_out = cpol;
    tick(5);
    cs_n_out = 1'b1;
    si_out   = ~si_out;
    tick(10);
  endtask
endmodule

// >>> tb/smcs_slave_tb_top.sv
// self-checking bench for the serial memory command slave
`timescale 1ns/1ns
module smcs_slave_tb_top;
  logic       clk_in;
  logic       rst_in;
  wire        cs_n;
  wire        sck;
  wire        si;
  wire        hold_n;
  wire        wp_n;
  logic       so_out;
  logic       so_oe_out;
  wire        so_w;
  logic [7:0] mem_m [2048];
  logic [7:0] exp_q [$];
  logic [7:0] rx_sh;
  logic [7:0] t2 [8];
  int         rx_n;
  logic [1:0] bp_m;
  logic       lock_m;
  logic       wel_m;
  logic       wp_m;
  int         err_total;
  int         n_checks;
  int         bp;

  assign so_w = so_oe_out ? so_out : 1'bz;

  smcs_slave i_dut (.clk_in(clk_in), .rst_in(rst_in), .cs_n_in(cs_n), .sck_in(sck),
    .si_in(si), .hold_n_in(hold_n), .wp_n_in(wp_n), .so_out(so_out), .so_oe_out(so_oe_out));
  smcs_host i_host (.clk_in(clk_in), .cs_n_out(cs_n), .sck_out(sck), .si_out(si),
    .hold_n_out(hold_n), .wp_n_out(wp_n));

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // read data taken on the rising clock, as a mode 0/3 host does
  always @(posedge sck) begin
    if (cs_n === 1'b0 && so_oe_out === 1'b1) begin
      rx_sh = {rx_sh[6:0], so_w};
      rx_n++;
      if (rx_n == 8) begin
        rx_n = 0;
        if (exp_q.size() > 0) begin
          check(rx_sh, exp_q.pop_front());
        end else begin
          check({7'h00, so_oe_out}, 8'h00);
        end
      end
    end
  end

  always @(posedge cs_n) rx_n = 0;

  function automatic bit prot(input logic [10:0] a);
    case (bp_m)
      smcs_pkg::BP_NONE:    return 1'b0;
      smcs_pkg::BP_QUARTER: return a >= smcs_pkg::PROT_QUARTER_BASE;
      smcs_pkg::BP_HALF:    return a >= smcs_pkg::PROT_HALF_BASE;
      default:              return 1'b1;
    endcase
  endfunction

  task automatic cmd(input logic [7:0] c);
    logic [7:0] t [8];
    t[0] = c;
    if (c == smcs_pkg::CMD_LATCH_SET) wel_m = 1'b1;
    if (c == smcs_pkg::CMD_LATCH_CLEAR) wel_m = 1'b0;
    i_host.frame(t, 1, 0, 1'b0, -1);
    check({7'h00, so_w}, {7'h00, 1'bz});
  endtask

  task automatic sread(input bit cpol);
    logic [7:0] t [8];
    t[0] = smcs_pkg::CMD_STATUS_READ;
    exp_q.push_back({lock_m, 3'h0, bp_m, wel_m, 1'b0});
    i_host.frame(t, 1, 1, cpol, -1);
  endtask

  task automatic swrite(input logic [7:0] v);
    logic [7:0] t [8];
    t[0] = smcs_pkg::CMD_STATUS_WRITE;
    t[1] = v;
    // refused without latch or when pin-locked; refusal keeps the latch
    if (wel_m && !(lock_m && !wp_m)) begin
      lock_m = v[7];
      bp_m   = v[3:2];
      wel_m  = 1'b0;
    end
    i_host.frame(t, 2, 0, 1'b0, -1);
  endtask

  task automatic mwrite(input logic [15:0] a, input int n);
    logic [7:0]  t [8];
    logic [10:0] p;
    int          i;
    t[0] = smcs_pkg::CMD_MEM_WRITE;
    t[1] = a[15:8];
    t[2] = a[7:0];
    p    = a[10:0];
    for (i = 0; i < n; i++) begin
      t[3+i] = 8'($urandom);
      if (wel_m && !prot(p)) mem_m[p] = t[3+i];
      p = p + 11'h001;
    end
    wel_m = 1'b0;
    i_host.frame(t, 3 + n, 0, 1'b0, -1);
  endtask

  task automatic mread(input logic [15:0] a, input int n, input int pa);
    logic [7:0]  t [8];
    logic [10:0] p;
    int          i;
    t[0] = smcs_pkg::CMD_MEM_READ;
    t[1] = a[15:8];
    t[2] = a[7:0];
    p    = a[10:0];
    for (i = 0; i < n; i++) begin
      exp_q.push_back(mem_m[p]);
      p = p + 11'h001;
    end
    i_host.frame(t, 3, n, 1'b0, pa);
  endtask

  task automatic set_wp(input logic v);
    wp_m = v;
    i_host.set_wp(v);
  endtask

  initial begin
    rst_in = 1'b1;
    wel_m  = 1'b0;
    lock_m = 1'b0;
    bp_m   = 2'h0;
    wp_m   = 1'b1;
    void'($urandom(65));
    repeat (8) @(posedge clk_in);
    @(negedge clk_in);
    rst_in = 1'b0;
    repeat (3) @(negedge clk_in);
    sread(1'b0);
    cmd(smcs_pkg::CMD_LATCH_SET);
    sread(1'b1);
    cmd(smcs_pkg::CMD_LATCH_CLEAR);
    sread(1'b0);
    cmd(smcs_pkg::CMD_LATCH_SET);
    mwrite(16'hfffe, 5);
    sread(1'b0);
    mread(16'h07fe, 5, -1);
    mwrite(16'h07fe, 2);
    mread(16'hf7fe, 2, 4);
    for (bp = 0; bp < 4; bp++) begin
      cmd(smcs_pkg::CMD_LATCH_SET);
      swrite({4'h7, 2'(bp), 2'h3});
      sread(1'b0);
      cmd(smcs_pkg::CMD_LATCH_SET);
      mwrite(16'h03fe, 5);
      cmd(smcs_pkg::CMD_LATCH_SET);
      mwrite(16'h05fe, 4);
      mread(16'h03fe, 5, -1);
      mread(16'h05fe, 4, -1);
    end
    // mid-run reset: latch drops, retained protection bits stay
    cmd(smcs_pkg::CMD_LATCH_SET);
    @(negedge clk_in);
    rst_in = 1'b1;
    repeat (8) @(negedge clk_in);
    rst_in = 1'b0;
    wel_m  = 1'b0;
    repeat (3) @(negedge clk_in);
    sread(1'b1);
    cmd(smcs_pkg::CMD_LATCH_SET);
    swrite(8'h80);
    set_wp(1'b0);
    cmd(smcs_pkg::CMD_LATCH_SET);
    mwrite(16'h0100, 2);
    mread(16'h0100, 2, -1);
    cmd(smcs_pkg::CMD_LATCH_SET);
    swrite(8'h0c);
    sread(1'b0);
    set_wp(1'b1);
    swrite(8'h00);
    sread(1'b0);
    swrite(8'h0c);
    sread(1'b0);
    cmd(smcs_pkg::CMD_LATCH_SET);
    t2[0] = smcs_pkg::CMD_LATCH_CLEAR;
    t2[1] = smcs_pkg::CMD_LATCH_SET;
    wel_m = 1'b0;
    i_host.frame(t2, 2, 0, 1'b0, -1);
    sread(1'b0);
    check(8'(exp_q.size()), 8'h00);
    conclude();
  end

  initial begin
    #2000000;
    err_total++;
    conclude();
  end
endmodule
